// [pkg/radio_cmd_consts.svh]
// constants for the channel switch and address command handler
`ifndef RADIO_CMD_CONSTS_SVH
`define RADIO_CMD_CONSTS_SVH
`define CAT_GENERAL        8'h00
`define CODE_CHAN_SWITCH   16'h0010
`define CODE_ADDR_MANAGE   16'h0011
`define TAG_ILLEGAL        8'h00
`define TAG_RESPONSE       8'hFF
`define OFF_CATEGORY       0
`define OFF_CODE_LO        1
`define OFF_CODE_HI        2
`define OFF_TAG            3
`define OFF_COUNTDOWN      4
`define OFF_CHANNEL        5
`define OFF_OPMAP          4
`define OFF_ADDR_CMD       5
`define OFF_ADDR_EVT       4
`define OFF_RESULT_CHAN    4
`define OFF_RESULT_ADDR    12
`define LEN_CHAN_CMD       4'h6
`define LEN_ADDR_CMD       4'hD
`define LEN_CHAN_EVT       4'h5
`define LEN_ADDR_EVT       4'hD
`define RES_SUCCESS        8'h00
`define RES_FAILURE        8'h01
`define RES_INVALID_PARAM  8'h05
`define RES_TIME_OUT       8'h07
`define ATYPE_SHORT        7'h00
`define ATYPE_EXT          7'h01
`define REG_CTRL           8'h00
`define REG_STATUS         8'h04
`define REG_SHORT_ADDR     8'h08
`define REG_EXT_LO         8'h0C
`define REG_EXT_HI         8'h10
`define RST_SHORT_ADDR     16'h0000
`define RST_CTRL_EN        1'b1
`define CLK_HZ             20000000
`define SWITCH_TIMEOUT_MS  100
`define SWITCH_TIMEOUT_CYC (`SWITCH_TIMEOUT_MS * (`CLK_HZ / 1000))
`endif

// [pkg/radio_cmd_pkg.sv]
// types for the channel switch and address command handler
package radio_cmd_pkg;
  typedef enum logic [1:0] {
    SW_IDLE     = 2'b00,
    SW_ANNOUNCE = 2'b01,
    SW_REPORT   = 2'b10
  } switch_state_e;

  typedef struct packed {
    logic [12:0][7:0] cmd_buf;
    logic [3:0]       cmd_idx;
    logic             cmd_done;
    logic             cmd_ready;
    switch_state_e    sw_state;
    logic [7:0]       sw_tag;
    logic [7:0]       sw_result;
    logic [7:0]       countdown;
    logic [7:0]       channel;
    logic             first_seen;
    logic [31:0]      sw_timer;
    logic             csie_include;
    logic             avail_mod;
    logic             stc_free_run;
    logic [15:0]      short_addr;
    logic             short_pend;
    logic [15:0]      src_addr;
    logic [63:0]      ext_addr;
    logic             ext_pend;
    logic [63:0]      dev_ident;
    logic [12:0][7:0] evt_buf;
    logic [3:0]       evt_len;
    logic [3:0]       evt_idx;
    logic             evt_valid;
    logic [7:0]       evt_byte;
    logic             evt_last;
    logic             ctrl_en;
    logic [31:0]      rd_data;
  } state_s;
endpackage

// [tb/host_ctrl_model.sv]
// host side model: sends command blocks and takes event blocks
`timescale 1ns/10ps
`default_nettype none
module host_ctrl_model (
  input  wire logic       clk_in,
  input  wire logic       cmd_ready_in,
  input  wire logic [7:0] evt_byte_in,
  input  wire logic       evt_valid_in,
  input  wire logic       evt_last_in,
  output logic [7:0]      cmd_byte_out,
  output logic            cmd_valid_out,
  output logic            cmd_last_out,
  output logic            evt_ready_out
);
  initial begin
    cmd_byte_out  = 8'h00;
    cmd_valid_out = 1'b0;
    cmd_last_out  = 1'b0;
    evt_ready_out = 1'b0;
  end

  // byte 0 category, 1-2 code, 3 tag, then parameters
  // each byte held until an edge samples ready high
  task automatic send_block(input logic [12:0][7:0] b, input int n);
    @(posedge clk_in);
    for (int i = 0; i < n; i++) begin
      cmd_byte_out  <= b[i];
      cmd_valid_out <= 1'b1;
      cmd_last_out  <= (i == n - 1);
      @(posedge clk_in);
      while (cmd_ready_in !== 1'b1) @(posedge clk_in);
    end
    cmd_valid_out <= 1'b0;
    cmd_last_out  <= 1'b0;
    cmd_byte_out  <= ~b[n-1];
  endtask

  // results only come back on the event stream
  task automatic get_event(input bit slow, output logic [12:0][7:0] e,
                           output int n);
    n = 0;
    e = '0;
    @(posedge clk_in);
    evt_ready_out <= 1'b1;
    for (int k = 0; k < 900 && n < 13; k++) begin
      @(posedge clk_in);
      if (evt_valid_in === 1'b1 && evt_ready_out === 1'b1) begin
        e[n] = evt_byte_in;
        n++;
        if (evt_last_in === 1'b1) break;
      end
      if (slow) evt_ready_out <= ~evt_ready_out;
    end
    evt_ready_out <= 1'b0;
  endtask
endmodule
`default_nettype wire

// [tb/radio_channel_addr_cmd_test.sv]
// self-checking bench for the channel switch and address handler
`timescale 1ns/10ps
`default_nettype none
module radio_channel_addr_cmd_test;
  localparam logic [63:0] PRESET = 64'h00000000A5A5F00D; // arbitrary value
  localparam int unsigned TMO    = 200;
  logic clk, rst_n, wr, rd, c_rdy, c_val, c_last, e_val, e_last, e_rdy;
  logic inc, avl, frun;
  logic [3:0] tick;
  logic [7:0] c_byte, e_byte, cd, ch, r_addr;
  logic [15:0] src;
  logic [31:0] wdata, rdata, rv;
  logic [63:0] dev;
  logic [12:0][7:0] ev;
  int ev_n, fails, n_tests, cyc;

  radio_channel_addr_cmd #(.SWITCH_TIMEOUT(TMO), .EXT_PRESET(PRESET))
  radio_channel_addr_cmd_i (
    .ref_clk_in(clk), .arst_n_in(rst_n), .cmd_byte_in(c_byte),
    .cmd_valid_in(c_val), .cmd_last_in(c_last), .cmd_ready_out(c_rdy),
    .evt_byte_out(e_byte), .evt_valid_out(e_val), .evt_last_out(e_last),
    .evt_ready_in(e_rdy), .superframe_start_in(tick[0]),
    .beacon_sent_in(tick[1]), .switch_fail_in(tick[2]),
    .beacon_resume_in(tick[3]), .csie_include_out(inc),
    .csie_countdown_out(cd), .csie_channel_out(ch),
    .avail_modify_out(avl), .stc_free_run_out(frun), .src_addr_out(src),
    .dev_ident_out(dev), .reg_addr_in(r_addr), .reg_wdata_in(wdata),
    .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata));

  host_ctrl_model host_ctrl_model_i (
    .clk_in(clk), .cmd_ready_in(c_rdy), .evt_byte_in(e_byte),
    .evt_valid_in(e_val), .evt_last_in(e_last), .cmd_byte_out(c_byte),
    .cmd_valid_out(c_val), .cmd_last_out(c_last), .evt_ready_out(e_rdy));

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  task automatic chk(input logic [63:0] got, exp, input string what);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED at %0t: %s", $time, what);
    end
  endtask

  task automatic pulse(input int k);
    @(posedge clk);
    tick <= 4'(1 << k);
    @(posedge clk);
    tick <= 4'h0;
    repeat (2) @(posedge clk);
    #1;
  endtask

  task automatic reg_acc(input bit w, input logic [7:0] a,
                         input logic [31:0] d);
    @(posedge clk);
    wr <= w;
    rd <= !w;
    r_addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
    rd <= 1'b0;
    #1;
    rv = rdata;
  endtask

  task automatic cmd(input logic [7:0] code, tag, p4,
                     input logic [63:0] a, input int n);
    logic [12:0][7:0] b;
    b = '0;
    b[1] = code;
    b[3] = tag;
    b[4] = p4;
    b[12:5] = a;
    host_ctrl_model_i.send_block(b, n);
  endtask

  task automatic evt(input bit slow, input logic [7:0] code, tag, res,
                     input int n);
    host_ctrl_model_i.get_event(slow, ev, ev_n);
    chk(ev_n, n, "event length");
    chk({ev[2], ev[0]}, 0, "event category");
    chk(ev[1], code, "event code");
    chk(ev[3], tag, "event tag");
    chk(ev[n-1], res, "completion code");
  endtask

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_switch();
    cmd(8'h10, 8'h05, 8'h02, 64'h09, 6);
    repeat (3) @(posedge clk);
    #1;
    chk(inc, 1, "element on");
    chk(cd, 8'h02, "first countdown");
    chk(ch, 8'h09, "new channel");
    chk(avl, 1, "availability altered");
    reg_acc(0, 8'h04, 0);
    chk(rv, 32'h0001_0902, "status");
    pulse(1);
    pulse(0);
    chk(cd, 8'h01, "countdown minus one");
    pulse(1);
    pulse(0);
    chk(cd, 8'h00, "countdown zero");
    chk(inc, 1, "element still on");
    pulse(1);
    evt(0, 8'h10, 8'h05, 8'h00, 5);
    chk(inc, 0, "element off");
    chk(frun, 1, "free run after switch");
    pulse(3);
    chk(frun, 0, "free run ends");
    $display("test switch done");
  endtask

  task automatic t_fail();
    cmd(8'h10, 8'h21, 8'h03, 64'h04, 6);
    pulse(2);
    evt(1, 8'h10, 8'h21, 8'h01, 5);
    cmd(8'h10, 8'h22, 8'h03, 64'h04, 6);
    evt(0, 8'h10, 8'h22, 8'h07, 5);
    chk(inc, 0, "element off after abort");
    $display("test fail done");
  endtask

  task automatic t_addr();
    cmd(8'h11, 8'h07, 8'h01, 64'h1234, 13);
    evt(0, 8'h11, 8'h07, 8'h00, 13);
    chk(src, 16'h0000, "source held");
    pulse(0);
    chk(src, 16'h1234, "source applied");
    cmd(8'h11, 8'h08, 8'h00, 64'hFFFF, 13);
    evt(1, 8'h11, 8'h08, 8'h00, 13);
    chk({ev[5], ev[4]}, 16'h1234, "short read");
    cmd(8'h11, 8'h09, 8'h02, 64'h0, 13);
    evt(0, 8'h11, 8'h09, 8'h00, 13);
    chk(ev[11:4], PRESET, "preset read");
    cmd(8'h11, 8'h0A, 8'h03, 64'hFEDCBA9876543210, 13);
    evt(0, 8'h11, 8'h0A, 8'h00, 13);
    chk(dev, PRESET, "identifier held");
    cmd(8'h11, 8'h0B, 8'h01, 64'hBEEF, 13);
    evt(0, 8'h11, 8'h0B, 8'h00, 13);
    pulse(0);
    chk(dev, 64'hFEDCBA9876543210, "identifier applied");
    chk(src, 16'hBEEF, "second source");
    cmd(8'h11, 8'h0C, 8'h02, 64'h0, 13);
    evt(0, 8'h11, 8'h0C, 8'h00, 13);
    chk(ev[11:4], 64'hFEDCBA9876543210, "assigned read");
    cmd(8'h11, 8'h0D, 8'h05, 64'h5555, 13);
    evt(0, 8'h11, 8'h0D, 8'h05, 13);
    cmd(8'h11, 8'h0E, 8'h00, 64'h0, 13);
    evt(0, 8'h11, 8'h0E, 8'h00, 13);
    chk({ev[5], ev[4]}, 16'hBEEF, "reserved stored nothing");
    $display("test address done");
  endtask

  task automatic t_regs_tags();
    logic [7:0] bad [2] = '{8'h00, 8'hFF};
    reg_acc(0, 8'h08, 0);
    chk(rv, 32'h0000BEEF, "short register");
    reg_acc(0, 8'h0C, 0);
    chk(rv, 32'h76543210, "ext low");
    reg_acc(0, 8'h10, 0);
    chk(rv, 32'hFEDCBA98, "ext high");
    reg_acc(0, 8'h20, 0);
    chk(rv, 0, "unmapped read");
    reg_acc(1, 8'h00, 0);
    #50;
    chk(c_rdy, 0, "intake off");
    reg_acc(1, 8'h00, 1);
    #50;
    chk(c_rdy, 1, "intake on");
    for (int i = 0; i < 2; i++) begin
      cmd(8'h10, bad[i], 8'h02, 64'h09, 6);
      repeat (8) @(posedge clk);
      #1;
      chk(e_val, 0, "bad tag no event");
      chk(inc, 0, "bad tag no switch");
    end
    cmd(8'h13, 8'h10, 8'h00, 64'h0, 6);
    cmd(8'h11, 8'h0F, 8'h00, 64'h0, 13);
    evt(0, 8'h11, 8'h0F, 8'h00, 13);
    chk({ev[5], ev[4]}, 16'hBEEF, "intake after drops");
    $display("test registers and tags done");
  endtask

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // ------------------------------------------------------------
  // clock, watchdog, main sequence
  // ------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      give_verdict();
    end
  end

  initial begin
    {rst_n, wr, rd, tick, r_addr, wdata} = '0;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
    chk(src, 16'h0000, "source after reset");
    chk(dev, PRESET, "identifier after reset");
    chk({inc, avl, frun}, 0, "switch outputs after reset");
    t_switch();
    t_fail();
    t_addr();
    t_regs_tags();
    give_verdict();
  end
endmodule
`default_nettype wire

// [verilog/radio_channel_addr_cmd.sv]
// channel switch and address management command handler
`timescale 1ns/10ps
`default_nettype none
`include "radio_cmd_consts.svh"

module radio_channel_addr_cmd #(
  parameter int unsigned    SWITCH_TIMEOUT = `SWITCH_TIMEOUT_CYC,
  parameter logic [63:0]    EXT_PRESET     = 64'h0123456789ABCDEF
) (
  input  wire logic        ref_clk_in,
  input  wire logic        arst_n_in,
  input  wire logic [7:0]  cmd_byte_in,
  input  wire logic        cmd_valid_in,
  input  wire logic        cmd_last_in,
  output logic             cmd_ready_out,
  output logic [7:0]       evt_byte_out,
  output logic             evt_valid_out,
  output logic             evt_last_out,
  input  wire logic        evt_ready_in,
  input  wire logic        superframe_start_in,
  input  wire logic        beacon_sent_in,
  input  wire logic        switch_fail_in,
  input  wire logic        beacon_resume_in,
  output logic             csie_include_out,
  output logic [7:0]       csie_countdown_out,
  output logic [7:0]       csie_channel_out,
  output logic             avail_modify_out,
  output logic             stc_free_run_out,
  output logic [15:0]      src_addr_out,
  output logic [63:0]      dev_ident_out,
  input  wire logic [7:0]  reg_addr_in,
  input  wire logic [31:0] reg_wdata_in,
  input  wire logic        reg_wr_in,
  input  wire logic        reg_rd_in,
  output logic [31:0]      reg_rdata_out
);
  radio_cmd_pkg::state_s q;
  radio_cmd_pkg::state_s next_q;
  logic                  cmd_ok;
  logic                  chan_go;
  logic                  addr_go;
  logic                  report_go;
  logic [6:0]            atype;
  logic                  awrite;
  logic [15:0]           cmd_code;

  // ------------------------------------------------------------
  // command decode
  // ------------------------------------------------------------
  always_comb begin
    cmd_code = {q.cmd_buf[`OFF_CODE_HI], q.cmd_buf[`OFF_CODE_LO]};
    atype    = q.cmd_buf[`OFF_OPMAP][7:1];
    awrite   = q.cmd_buf[`OFF_OPMAP][0];
    cmd_ok   = q.cmd_done &&
               q.cmd_buf[`OFF_CATEGORY] == `CAT_GENERAL &&
               (cmd_code == `CODE_CHAN_SWITCH ||
                cmd_code == `CODE_ADDR_MANAGE) &&
               q.cmd_buf[`OFF_TAG] != `TAG_ILLEGAL &&
               q.cmd_buf[`OFF_TAG] != `TAG_RESPONSE;
    report_go = q.sw_state == radio_cmd_pkg::SW_REPORT && !q.evt_valid;
    chan_go  = cmd_ok && !report_go && !q.evt_valid &&
               cmd_code == `CODE_CHAN_SWITCH;
    addr_go  = cmd_ok && !report_go && !q.evt_valid &&
               cmd_code == `CODE_ADDR_MANAGE;
  end

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    logic [3:0] len;
    logic [7:0] res;
    len    = q.cmd_idx;
    res    = `RES_SUCCESS;
    next_q = q;

    // command byte intake, bytes past the longest block are dropped
    if (q.cmd_ready && cmd_valid_in) begin
      if (q.cmd_idx < `LEN_ADDR_CMD) begin
        next_q.cmd_buf[q.cmd_idx] = cmd_byte_in;
        next_q.cmd_idx            = q.cmd_idx + 4'h1;
      end
      if (cmd_last_in)
        next_q.cmd_done = 1'b1;
    end
    // dropped blocks free the intake buffer too
    if (q.cmd_done && !cmd_ok) begin
      next_q.cmd_done = 1'b0;
      next_q.cmd_idx  = 4'h0;
    end

    // switch sequencing
    if (q.sw_state == radio_cmd_pkg::SW_ANNOUNCE) begin
      next_q.sw_timer = q.sw_timer + 32'h1;
      if (superframe_start_in && q.first_seen && q.countdown != 8'h00)
        next_q.countdown = q.countdown - 8'h01;
      if (beacon_sent_in)
        next_q.first_seen = 1'b1;
      if (switch_fail_in) begin
        next_q.sw_state  = radio_cmd_pkg::SW_REPORT;
        next_q.sw_result = `RES_FAILURE;
      end else if (q.sw_timer == SWITCH_TIMEOUT - 1) begin
        next_q.sw_state  = radio_cmd_pkg::SW_REPORT;
        next_q.sw_result = `RES_TIME_OUT;
      end else if (beacon_sent_in && q.countdown == 8'h00) begin
        next_q.sw_state  = radio_cmd_pkg::SW_REPORT;
        next_q.sw_result = `RES_SUCCESS;
      end
    end

    if (beacon_resume_in)
      next_q.stc_free_run = 1'b0;

    // addresses take effect at the next superframe
    // a write in the same cycle stays pending, so it is not lost
    if (superframe_start_in) begin
      if (q.short_pend) begin
        next_q.src_addr   = q.short_addr;
        next_q.short_pend = 1'b0;
      end
      if (q.ext_pend) begin
        next_q.dev_ident = q.ext_addr;
        next_q.ext_pend  = 1'b0;
      end
    end

    // event loading, switch report first
    if (report_go) begin
      next_q.sw_state     = radio_cmd_pkg::SW_IDLE;
      next_q.csie_include = 1'b0;
      next_q.avail_mod    = 1'b0;
      if (q.sw_result == `RES_SUCCESS)
        next_q.stc_free_run = 1'b1;
      next_q.evt_buf      = '0;
      next_q.evt_buf[`OFF_CODE_LO]     = 8'(`CODE_CHAN_SWITCH);
      next_q.evt_buf[`OFF_TAG]         = q.sw_tag;
      next_q.evt_buf[`OFF_RESULT_CHAN] = q.sw_result;
      next_q.evt_len      = `LEN_CHAN_EVT;
    end else if (chan_go) begin
      next_q.cmd_done = 1'b0;
      next_q.evt_buf  = '0;
      next_q.evt_buf[`OFF_CODE_LO] = 8'(`CODE_CHAN_SWITCH);
      next_q.evt_buf[`OFF_TAG]     = q.cmd_buf[`OFF_TAG];
      if (len < `LEN_CHAN_CMD)
        res = `RES_INVALID_PARAM;
      else if (q.sw_state != radio_cmd_pkg::SW_IDLE)
        res = `RES_FAILURE;
      if (res != `RES_SUCCESS) begin
        next_q.evt_buf[`OFF_RESULT_CHAN] = res;
        next_q.evt_len = `LEN_CHAN_EVT;
      end else begin
        next_q.sw_state     = radio_cmd_pkg::SW_ANNOUNCE;
        next_q.sw_tag       = q.cmd_buf[`OFF_TAG];
        next_q.countdown    = q.cmd_buf[`OFF_COUNTDOWN];
        next_q.channel      = q.cmd_buf[`OFF_CHANNEL];
        next_q.csie_include = 1'b1;
        next_q.avail_mod    = 1'b1;
        next_q.first_seen   = 1'b0;
        next_q.sw_timer     = 32'h0;
      end
    end else if (addr_go) begin
      next_q.cmd_done = 1'b0;
      next_q.evt_buf  = '0;
      next_q.evt_buf[`OFF_CODE_LO] = 8'(`CODE_ADDR_MANAGE);
      next_q.evt_buf[`OFF_TAG]     = q.cmd_buf[`OFF_TAG];
      next_q.evt_len  = `LEN_ADDR_EVT;
      if (len < `LEN_ADDR_CMD || atype > `ATYPE_EXT) begin
        res = `RES_INVALID_PARAM;
      end else if (atype == `ATYPE_SHORT) begin
        if (awrite) begin
          next_q.short_addr = {q.cmd_buf[`OFF_ADDR_CMD + 1],
                               q.cmd_buf[`OFF_ADDR_CMD]};
          next_q.short_pend = 1'b1;
        end else begin
          next_q.evt_buf[`OFF_ADDR_EVT]     = q.short_addr[7:0];
          next_q.evt_buf[`OFF_ADDR_EVT + 1] = q.short_addr[15:8];
        end
      end else if (awrite) begin
        next_q.ext_addr = q.cmd_buf[`OFF_ADDR_CMD +: 8];
        next_q.ext_pend = 1'b1;
      end else begin
        next_q.evt_buf[`OFF_ADDR_EVT +: 8] = q.ext_addr;
      end
      next_q.evt_buf[`OFF_RESULT_ADDR] = res;
    end
    if (chan_go || addr_go)
      next_q.cmd_idx = 4'h0;
    // an accepted switch answers only when it finishes
    if (report_go || addr_go || (chan_go && res != `RES_SUCCESS)) begin
      next_q.evt_valid = 1'b1;
      next_q.evt_idx   = 4'h0;
      next_q.evt_byte  = next_q.evt_buf[0];
      next_q.evt_last  = 1'b0;
    end else if (q.evt_valid && evt_ready_in) begin
      // index never steps past the last byte of the block
      if (q.evt_last) begin
        next_q.evt_valid = 1'b0;
        next_q.evt_last  = 1'b0;
      end else begin
        next_q.evt_idx  = q.evt_idx + 4'h1;
        next_q.evt_byte = q.evt_buf[q.evt_idx + 4'h1];
        next_q.evt_last = q.evt_idx + 4'h2 == q.evt_len;
      end
    end

    // intake stalls while a block waits or an event is out
    next_q.cmd_ready = q.ctrl_en && !next_q.cmd_done &&
                       !next_q.evt_valid && !(cmd_valid_in &&
                       cmd_last_in && q.cmd_ready);

    // register port
    if (reg_wr_in && reg_addr_in == `REG_CTRL)
      next_q.ctrl_en = reg_wdata_in[0];
    next_q.rd_data = 32'h0;
    if (reg_rd_in) begin
      case (reg_addr_in)
        `REG_CTRL:       next_q.rd_data = {31'h0, q.ctrl_en};
        `REG_STATUS:     next_q.rd_data = {14'h0, q.stc_free_run,
                                           q.csie_include, q.channel,
                                           q.countdown};
        `REG_SHORT_ADDR: next_q.rd_data = {16'h0, q.short_addr};
        `REG_EXT_LO:     next_q.rd_data = q.ext_addr[31:0];
        `REG_EXT_HI:     next_q.rd_data = q.ext_addr[63:32];
        default:         next_q.rd_data = 32'h0;
      endcase
    end
  end

  // ------------------------------------------------------------
  // state register
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      q            <= '0;
      q.ext_addr   <= EXT_PRESET;
      q.dev_ident  <= EXT_PRESET;
      q.short_addr <= `RST_SHORT_ADDR;
      q.src_addr   <= `RST_SHORT_ADDR;
      q.ctrl_en    <= `RST_CTRL_EN;
    end else begin
      q <= next_q;
    end
  end

  assign cmd_ready_out      = q.cmd_ready;
  assign evt_byte_out       = q.evt_byte;
  assign evt_valid_out      = q.evt_valid;
  assign evt_last_out       = q.evt_last;
  assign csie_include_out   = q.csie_include;
  assign csie_countdown_out = q.countdown;
  assign csie_channel_out   = q.channel;
  assign avail_modify_out   = q.avail_mod;
  assign stc_free_run_out   = q.stc_free_run;
  assign src_addr_out       = q.src_addr;
  assign dev_ident_out      = q.dev_ident;
  assign reg_rdata_out      = q.rd_data;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!arst_n_in);

  sequence zero_beacon_s;
    q.sw_state == radio_cmd_pkg::SW_ANNOUNCE && beacon_sent_in &&
    q.countdown == 8'h00 && !switch_fail_in &&
    q.sw_timer != SWITCH_TIMEOUT - 1;
  endsequence
  sequence report_load_s;
    q.sw_state == radio_cmd_pkg::SW_REPORT && !q.evt_valid;
  endsequence

  element_pending_a: assert property (
    q.sw_state == radio_cmd_pkg::SW_ANNOUNCE |-> csie_include_out)
    else $error("element missing while switch pending");
  countdown_step_a: assert property (
    q.sw_state == radio_cmd_pkg::SW_ANNOUNCE && superframe_start_in &&
    q.first_seen && q.countdown != 8'h00 && !beacon_sent_in |=>
    csie_countdown_out == $past(q.countdown) - 8'h01)
    else $error("countdown did not step by one");
  avail_pair_a: assert property (
    avail_modify_out == csie_include_out)
    else $error("availability not altered with element");
  channel_copy_a: assert property (
    $rose(csie_include_out) |-> csie_channel_out == $past(q.cmd_buf[5]))
    else $error("target channel not copied");
  switch_done_a: assert property (
    zero_beacon_s ##1 report_load_s |=> evt_valid_out &&
    q.evt_buf[1] == 8'h10 && q.evt_buf[4] == 8'h00 && evt_byte_out == 8'h00)
    else $error("switch completion event wrong");
  switch_fail_a: assert property (
    q.sw_state == radio_cmd_pkg::SW_ANNOUNCE && switch_fail_in |=>
    q.sw_state == radio_cmd_pkg::SW_REPORT && q.sw_result == 8'h01)
    else $error("failure not reported");
  free_run_a: assert property (
    report_load_s and (q.sw_result == 8'h00) |=> stc_free_run_out)
    else $error("offset counter not free running");
  tag_echo_a: assert property (
    report_load_s |=> q.evt_buf[3] == $past(q.sw_tag) &&
    q.evt_buf[3] != 8'h00 && q.evt_buf[3] != 8'hFF)
    else $error("event tag differs from command tag");
  src_addr_a: assert property (
    superframe_start_in && q.short_pend |=> src_addr_out == $past(q.short_addr))
    else $error("source address not applied");
  reserved_type_a: assert property (
    addr_go && atype > 7'h01 |=> $stable(q.short_addr) &&
    $stable(q.ext_addr) && q.evt_buf[12] == 8'h05)
    else $error("reserved type not rejected");
  switch_timeout_a: assert property (
    q.sw_state == radio_cmd_pkg::SW_ANNOUNCE && !switch_fail_in &&
    q.sw_timer == SWITCH_TIMEOUT - 1 |=>
    q.sw_state == radio_cmd_pkg::SW_REPORT && q.sw_result == 8'h07)
    else $error("switch timeout not reported");
  switch_silent_a: assert property (
    chan_go && q.sw_state == radio_cmd_pkg::SW_IDLE && q.cmd_idx > 4'h5 |=>
    !evt_valid_out && csie_include_out)
    else $error("switch answered before it finished");
  ident_apply_a: assert property (
    superframe_start_in && q.ext_pend |=> dev_ident_out == $past(q.ext_addr))
    else $error("device identifier not applied");
  addr_event_a: assert property (
    addr_go |=> evt_valid_out && q.evt_len == 4'hD &&
    q.evt_buf[1] == 8'h11 && q.evt_buf[3] == $past(q.cmd_buf[3]))
    else $error("address event block wrong");
  short_read_a: assert property (
    addr_go && atype == 7'h00 && !awrite && q.cmd_idx == 4'hD |=>
    q.evt_buf[5:4] == $past(q.short_addr))
    else $error("short address not returned");
  intake_stall_a: assert property (
    evt_valid_out |-> !cmd_ready_out)
    else $error("intake open while event is out");
  bad_tag_drop_a: assert property (
    q.cmd_done && (q.cmd_buf[3] == 8'h00 || q.cmd_buf[3] == 8'hFF) |=>
    !q.cmd_done && q.cmd_idx == 4'h0 && $stable(q.short_addr))
    else $error("illegal tag block not dropped");
endmodule
`default_nettype wire
